// >>> verilog/swr_pkg.sv
// Constants shared by the supervisor watchdog reset block.
// Assumes a 10 MHz system clock; all timing counts are derived from it.
package swr_pkg;

  // --------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned RST_PULSE_MS    = 500;
  localparam int unsigned WDOG_TIMEOUT_MS = 700;
  localparam int unsigned STROBE_MIN_NS   = 500;
  localparam int unsigned DEBOUNCE_NS     = 500;
  // Least times round up, nominal timeout rounds down.
  localparam int unsigned RST_PULSE_CYC   =
    (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_TIMEOUT_CYC = (WDOG_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_MIN_CYC  =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC    =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------
  // Widths and reset values
  // --------------------------------------------------------------------
  localparam int unsigned CNT_W      = 24;
  localparam int unsigned FILT_W     = 4;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 24'h000000;
  localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;

  // Supervisor states, one-hot.
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,   // Reset line driven low.
    ST_RUN  = 3'h2,   // Line released, watchdog counting.
    ST_EXT  = 3'h4    // Outside agent pulled line low; goes to ST_HOLD on the next cycle.
  } swr_state_t;

endpackage : swr_pkg

// >>> verilog/swr_filt_if.sv
// Carrier between the supervisor top and its input filter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface swr_filt_if;
  logic rawLevel;
  logic stableLevel;
  logic fallPulse;
  modport filt (input rawLevel, output stableLevel, output fallPulse);
  modport user (output rawLevel, input stableLevel, input fallPulse);
endinterface : swr_filt_if

// >>> verilog/swr_filter.sv
// Input filter: a level must hold for a number of cycles before it is believed.
// Assumes a synchronous input and a clock enable shared with the top.
`timescale 1ns/10ps
module swr_filter
  import swr_pkg::*;
#(
  parameter int unsigned HOLD_CYC = DEBOUNCE_CYC
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  // Filter channel
  swr_filt_if.filt f
);

  typedef struct packed {
    logic              stable;
    logic              fall;
    logic [FILT_W-1:0] cnt;
  } swr_filt_t;

  swr_filt_t st_q, st_d;

  // --------------------------------------------------------------------
  // Filter logic
  // --------------------------------------------------------------------
  // A changed level restarts its own count; bounce never reaches the output.
  always_comb begin
    st_d      = st_q;
    st_d.fall = 1'b0;
    if (f.rawLevel == st_q.stable) begin
      st_d.cnt = FILT_ZERO;
    end else if (st_q.cnt >= FILT_W'(HOLD_CYC - 1)) begin
      st_d.stable = f.rawLevel;
      st_d.fall   = ~f.rawLevel;
      st_d.cnt    = FILT_ZERO;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // Line idles high, so the believed level starts high.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '{stable: 1'b1, fall: 1'b0, cnt: FILT_ZERO};
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign f.stableLevel = st_q.stable;
  assign f.fallPulse   = st_q.fall & clkEn;

endmodule : swr_filter

// >>> verilog/swr_supervisor.sv
// Supervisor watchdog reset: drives one open-drain reset/strobe line.
// Assumes line levels arrive already sliced into low and strobe-low inputs.
`timescale 1ns/10ps
module swr_supervisor
  import swr_pkg::*;
#(
  parameter int unsigned PULSE_CYC   = RST_PULSE_CYC,
  parameter int unsigned TIMEOUT_CYC = WDOG_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  // Supply monitor
  input  wire logic supplyLow,
  // Reset/strobe line, open drain
  input  wire logic lineLowIn,
  input  wire logic strobeLowIn,
  output logic      lineOut,
  output logic      lineOe
);

  typedef struct packed {
    swr_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic             drive;
  } swr_sup_t;

  swr_sup_t st_q, st_d;

  swr_filt_if lineF ();
  swr_filt_if strbF ();

  // --------------------------------------------------------------------
  // Input filters
  // --------------------------------------------------------------------
  // The line filter sees the line only while we do not drive it ourselves.
  assign lineF.rawLevel = ~(lineLowIn & ~st_q.drive);
  assign strbF.rawLevel = ~strobeLowIn;

  swr_filter #(.HOLD_CYC(DEBOUNCE_CYC)) uLineFilt (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .f       (lineF.filt)
  );

  swr_filter #(.HOLD_CYC(STROBE_MIN_CYC)) uStrbFilt (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .f       (strbF.filt)
  );

  // --------------------------------------------------------------------
  // Supervisor state machine
  // --------------------------------------------------------------------
  // The pulse counter is also the watchdog counter; one counter saves area
  // since the two intervals never run at the same time.
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      ST_HOLD: begin
        st_d.drive = 1'b1;
        if (supplyLow) begin
          st_d.cnt = CNT_ZERO;
        end else if (st_q.cnt >= CNT_W'(PULSE_CYC - 1)) begin
          st_d.state = ST_RUN;
          st_d.cnt   = CNT_ZERO;
          st_d.drive = 1'b0;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      ST_RUN: begin
        st_d.drive = 1'b0;
        if (!lineF.stableLevel) begin
          st_d.state = ST_EXT;
          st_d.cnt   = CNT_ZERO;
        end else if (strbF.fallPulse) begin
          st_d.cnt = CNT_ZERO;
        end else if (st_q.cnt >= CNT_W'(TIMEOUT_CYC - 1)) begin
          // timeout asserts reset; repeats since we come back here
          st_d.state = ST_HOLD;
          st_d.cnt   = CNT_ZERO;
          st_d.drive = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      ST_EXT: begin
        // stretch outside request; the count runs while held low.
        st_d.drive = 1'b1;
        st_d.state = ST_HOLD;
        st_d.cnt   = CNT_ZERO;
      end
      default: begin
        st_d.state = ST_HOLD;
        st_d.cnt   = CNT_ZERO;
        st_d.drive = 1'b1;
      end
    endcase
    if (supplyLow) begin
      st_d.state = ST_HOLD;
      st_d.cnt   = CNT_ZERO;
      st_d.drive = 1'b1;
    end
  end

  // Reset starts in the hold state so the line is low from power-on.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '{state: ST_HOLD, cnt: CNT_ZERO, drive: 1'b1};
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  // Open drain: only ever drive low.
  assign lineOut = 1'b0;
  assign lineOe  = st_q.drive;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Cycles the line has been driven, saturating at the pulse length.
  int unsigned holdCnt;
  always_ff @(posedge clk_sys) begin
    if (reset || !lineOe) begin
      holdCnt <= 0;
    end else if (clkEn && holdCnt < PULSE_CYC) begin
      holdCnt <= holdCnt + 1;
    end
  end

  // Cycles since supply last read low; the hold may only end once this
  // has reached one less than the pulse length. Frozen cycles do not count.
  int unsigned supRecCnt;
  always_ff @(posedge clk_sys) begin
    if (reset || (clkEn && supplyLow)) begin
      supRecCnt <= 0;
    end else if (clkEn && supRecCnt < PULSE_CYC) begin
      supRecCnt <= supRecCnt + 1;
    end
  end

  // Cycles the line has stood released without a strobe. An outside
  // request seen on the last count adds one cycle before the pulse starts.
  int unsigned runCnt;
  always_ff @(posedge clk_sys) begin
    if (reset || lineOe || strbF.fallPulse) begin
      runCnt <= 0;
    end else if (clkEn) begin
      runCnt <= runCnt + 1;
    end
  end

  supply_drives_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && supplyLow |=> lineOe) else $error("Line not driven during supply low.");
  pulse_min_width_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lineOe) |-> $past(holdCnt) >= PULSE_CYC - 1) else $error("Reset pulse too short.");
  supply_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lineOe) |-> !$past(supplyLow)) else $error("Released during supply low.");
  strobe_clears_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && st_q.state == ST_RUN && strbF.fallPulse && lineF.stableLevel && !supplyLow
    |=> st_q.cnt == CNT_ZERO) else $error("Strobe did not clear watchdog.");
  timeout_fires_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q.state == ST_RUN && st_q.cnt >= CNT_W'(TIMEOUT_CYC - 1) && clkEn
    && lineF.stableLevel && !strbF.fallPulse |=> lineOe)
    else $error("Watchdog timeout missed.");
  release_restart_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lineOe) |-> st_q.cnt == CNT_ZERO) else $error("Count not restarted at release.");
  ext_request_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && st_q.state == ST_RUN && !lineF.stableLevel && !supplyLow |=> ##1 lineOe)
    else $error("Outside request ignored.");
  state_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot(st_q.state)) else $error("State not one-hot.");
  supply_hold_time_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lineOe) |-> $past(supRecCnt) >= PULSE_CYC - 1)
    else $error("Released too soon after supply recovery.");
  watchdog_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
    runCnt <= TIMEOUT_CYC + 1)
    else $error("Line released too long without a strobe.");
  hold_drives_line_a: assert property (@(posedge clk_sys) disable iff (reset)
    lineOe == (st_q.state == ST_HOLD))
    else $error("Line drive does not follow the hold state.");

  // Main scenarios: timeout, outside request, strobe, supply dip and release.
  cov_timeout_c: cover property (@(posedge clk_sys) disable iff (reset)
    st_q.state == ST_RUN ##1 st_q.state == ST_HOLD && !supplyLow);
  cov_ext_c: cover property (@(posedge clk_sys) disable iff (reset) st_q.state == ST_EXT);
  cov_strobe_c: cover property (@(posedge clk_sys) disable iff (reset)
    st_q.state == ST_RUN && strbF.fallPulse);
  cov_supply_c: cover property (@(posedge clk_sys) disable iff (reset)
    supplyLow ##1 lineOe);
  cov_release_c: cover property (@(posedge clk_sys) disable iff (reset)
    $fell(lineOe));

endmodule : swr_supervisor

// >>> tb/swr_proc_model.sv
// Processor model on the far side of the shared reset/strobe line.
// Assumes a pull-up divider holds the line high when nobody pulls it.
`timescale 1ns/10ps
module swr_proc_model
  import swr_pkg::*;
#(
  parameter int unsigned GAP_MAX = 25
) (
  // Clock
  input  wire logic clk_sys,
  // Bench control
  input  wire logic strobeEn,
  // Shared line
  input  wire logic lineOe,
  output logic      lineLowIn,
  output logic      strobeLowIn
);
  logic ioLow  = 1'b0;
  logic btnLow = 1'b0;

  // A hard pull to ground hides the divider's strobe level.
  assign lineLowIn   = lineOe | btnLow;
  assign strobeLowIn = ioLow & ~lineLowIn;

  initial begin
    forever begin
      @(negedge clk_sys);
      if (strobeEn && !lineOe) begin
        repeat (10 + $urandom_range(GAP_MAX)) @(negedge clk_sys);
        ioLow = 1'b1;
        repeat (STROBE_MIN_CYC + $urandom_range(3)) @(negedge clk_sys);
        ioLow = 1'b0;
      end
    end
  end

  task automatic press(input int holdCyc);
    repeat (3) begin
      btnLow = 1'b1;
      repeat ($urandom_range(3, 1)) @(negedge clk_sys);
      btnLow = 1'b0;
      @(negedge clk_sys);
    end
    btnLow = 1'b1;
    repeat (holdCyc) @(negedge clk_sys);
    btnLow = 1'b0;
  endtask : press
endmodule : swr_proc_model

// >>> tb/testbench.sv
// Self-checking bench for the supervisor watchdog reset block.
// Assumes the processor model stands on the far side of the line.
`timescale 1ns/10ps
module testbench;
  import swr_pkg::*;
  localparam int PULSE = 40;
  localparam int TOUT  = 60;
  logic clk_sys   = 1'b0;
  logic reset     = 1'b1;
  logic supplyLow = 1'b0;
  logic strobeEn  = 1'b0;
  logic clkEn     = 1'b1;
  logic lineLowIn, strobeLowIn, lineOut, lineOe;
  int   error_cnt = 0;
  int   cmp_count = 0;
  int   riseCnt   = 0;
  int   n, r0, dur;

  always #50 clk_sys = ~clk_sys;
  always @(posedge lineOe) riseCnt++;

  swr_supervisor #(.PULSE_CYC(PULSE), .TIMEOUT_CYC(TOUT)) i_swr_supervisor (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .supplyLow(supplyLow),
    .lineLowIn(lineLowIn), .strobeLowIn(strobeLowIn), .lineOut(lineOut), .lineOe(lineOe));
  swr_proc_model #(.GAP_MAX(25)) i_swr_proc_model (
    .clk_sys(clk_sys), .strobeEn(strobeEn), .lineOe(lineOe),
    .lineLowIn(lineLowIn), .strobeLowIn(strobeLowIn));

  // --------------------------------------------------------------------
  // Compare and measure helpers
  // --------------------------------------------------------------------
  task automatic chk_win(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_win

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  // Counts falling edges while the drive stays at one level.
  task automatic hold_len(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (lineOe === lvl && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask : hold_len

  // Pulse ends may land a few edges late, never early.
  function automatic int slack(input int base);
    return base + 3;
  endfunction : slack

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(85660));
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    hold_len(1'b1, 4 * PULSE, n);
    chk_win(n, PULSE - 1, slack(PULSE));
    // Without strobes the pulses must repeat every timeout.
    repeat (2) begin
      hold_len(1'b0, 4 * TOUT, n);
      chk_win(n, TOUT - 1, TOUT + 2);
      hold_len(1'b1, 4 * PULSE, n);
      chk_win(n, PULSE - 1, slack(PULSE));
    end
    strobeEn = 1'b1;
    hold_len(1'b0, 4 * TOUT, n);
    chk_win(n, 4 * TOUT, 4 * TOUT);
    for (int k = 0; k < 3; k++) begin
      dur = $urandom_range(30, 5);
      supplyLow = 1'b1;
      @(negedge clk_sys);
      chk_bit(lineOe, 1'b1);
      hold_len(1'b1, dur - 1, n);
      chk_win(n, dur - 1, dur - 1);
      supplyLow = 1'b0;
      hold_len(1'b1, 4 * PULSE, n);
      chk_win(n, PULSE - 1, slack(PULSE));
      r0 = riseCnt;
      fork
        i_swr_proc_model.press($urandom_range(15, 6));
        begin
          hold_len(1'b0, 40, n);
          hold_len(1'b1, 4 * PULSE, n);
        end
      join
      chk_win(n, PULSE - 1, slack(PULSE) + 1);
      hold_len(1'b0, 2 * TOUT, n);
      chk_win(riseCnt - r0, 1, 1);
      chk_bit(lineOut, 1'b0);
    end
    // A frozen clock enable stops the hold count, so the pulse grows by that span.
    supplyLow = 1'b1;
    @(negedge clk_sys);
    supplyLow = 1'b0;
    clkEn     = 1'b0;
    repeat ($urandom_range(12, 3)) @(negedge clk_sys);
    chk_bit(lineOe, 1'b1);
    clkEn = 1'b1;
    hold_len(1'b1, 4 * PULSE, n);
    chk_win(n, PULSE - 1, slack(PULSE));
    wrap_up();
  end

  // Watchdog: the sequence needs under 2000 cycles.
  initial begin
    #(6000 * 100);
    error_cnt++;
    wrap_up();
  end
endmodule : testbench
